// ==== hdl/vlc_map.svh ====
`ifndef VLC_MAP_SVH
`define VLC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VLC_OFS_LIMIT1      8'h00
`define VLC_OFS_LIMIT2      8'h04
`define VLC_OFS_LIMIT3      8'h08
`define VLC_OFS_CTRL        8'h0C
`define VLC_OFS_STATUS      8'h10
`define VLC_OFS_CAPS        8'h14

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define VLC_LIMIT_RST       4'h0
`define VLC_CTRL_RST        17'h00000
`define VLC_CTRL_WMASK      32'h0001F773
`define VLC_CTRL_BITS       17
`define VLC_ST_CHUNKS_LSB   4
`define VLC_ST_USABLE_BIT   9
`define VLC_ST_PRESERVE_BIT 10
`define VLC_ST_MASK_LSB     16
`define VLC_CAPS_SUP_LSB    16
`define VLC_CHUNK_BITS      128
`define VLC_MAX_SLOTS       16
`define VLC_CHUNKS_RST      5'h01
`define VLC_FIELD_RST       4'h0

`endif

// ==== hdl/vlc_pkg.sv ====
package vlc_pkg;

  typedef logic [3:0]  vlc_field_t;
  typedef logic [4:0]  vlc_chunks_t;
  typedef logic [15:0] vlc_mask_t;

  typedef enum logic [1:0] {
    VLC_LVL0 = 2'b00,
    VLC_LVL1 = 2'b01,
    VLC_LVL2 = 2'b10,
    VLC_LVL3 = 2'b11
  } vlc_level_t;

  // Control word as software sees it, high bit first
  typedef struct packed {
    logic       zero_fill;
    logic [3:0] narrow;
    logic       rsvd_b;
    logic [2:0] fp_en;
    logic       rsvd_a;
    logic [2:0] vec_en;
    logic [1:0] rsvd_0;
    vlc_level_t level;
  } vlc_ctrl_t;

endpackage

// ==== hdl/vlc_round.sv ====
`include "vlc_map.svh"

module vlc_round #(
  parameter logic [4:0]  MAX_CHUNKS = 5'h10,
  parameter logic [15:0] OPT_MASK   = 16'hFFFF
) (
  input  wire logic [4:0]  req_chunks,
  output logic      [4:0]  out_chunks,
  output logic      [15:0] sup_mask
);

  // ----------------------------------------
  // Supported lengths
  // ----------------------------------------
  function automatic logic is_pow2(input logic [4:0] n);
    return (n != 5'h00) && ((n & (n - 5'h01)) == 5'h00);
  endfunction

  genvar g;
  generate
    for (g = 0; g < `VLC_MAX_SLOTS; g++) begin : g_sup
      localparam logic [4:0] N = 5'(g + 1);
      // Maximum itself, required powers of two, optional others
      assign sup_mask[g] = (N == MAX_CHUNKS) ||
                           ((N < MAX_CHUNKS) && (is_pow2(N) || OPT_MASK[g]));
    end
  endgenerate

  // ----------------------------------------
  // Round down
  // ----------------------------------------
  always_comb begin
    out_chunks = 5'h01;
    for (int i = 0; i < `VLC_MAX_SLOTS; i++) begin
      if (sup_mask[i] && (5'(i + 1) <= req_chunks)) begin
        out_chunks = 5'(i + 1);
      end
    end
  end

endmodule

// ==== hdl/vlc_access.sv ====
module vlc_access (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  eff_chunks,
  input  wire logic        zero_fill,
  input  wire logic        preserve,
  output logic      [15:0] acc_mask_reg,
  output logic      [15:0] zero_req_reg
);

  logic [15:0] acc_mask_next;
  logic [15:0] zero_req_next;

  // ----------------------------------------
  // Accessible slices
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      acc_mask_next[i] = (5'(i) < eff_chunks);
    end
    // Zeroing of regained slices only when not in the preserve case
    zero_req_next = (acc_mask_next & ~acc_mask_reg) & {16{zero_fill & ~preserve}};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_mask_reg <= 16'h0001;
    end else begin
      acc_mask_reg <= acc_mask_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      zero_req_reg <= 16'h0000;
    end else begin
      zero_req_reg <= zero_req_next;
    end
  end

endmodule

// ==== hdl/vlc_top.sv ====
`include "vlc_map.svh"

module vlc_top #(
  parameter int unsigned MAX_LEN_BITS = 2048,
  parameter logic [15:0] OPT_LEN_MASK = 16'hFFFF,
  parameter bit          HAS_LEVEL2   = 1'b1,
  parameter bit          HAS_LEVEL3   = 1'b1
) (
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  output vlc_pkg::vlc_field_t     EFF_LEN_FIELD,
  output vlc_pkg::vlc_chunks_t    EFF_LEN_CHUNKS,
  output logic                    VEC_USABLE,
  output logic                    STATE_PRESERVE,
  output vlc_pkg::vlc_mask_t      ACC_MASK,
  output vlc_pkg::vlc_mask_t      ZERO_REQ
);
  import vlc_pkg::*;

  // ----------------------------------------
  // Sizing
  // ----------------------------------------
  // Maximum must be a multiple of 128 between 128 and 2048; others round down to a multiple of 128, then clamp
  localparam int unsigned RAW_CHUNKS = MAX_LEN_BITS / `VLC_CHUNK_BITS;
  localparam logic [4:0]  MAX_CHUNKS = (RAW_CHUNKS < 1) ? 5'h01 :
                                       (RAW_CHUNKS > `VLC_MAX_SLOTS) ? 5'h10 :
                                       5'(RAW_CHUNKS);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  logic        req_new;
  logic        wr_fire;

  vlc_field_t  limit1_reg;
  vlc_field_t  limit2_reg;
  vlc_field_t  limit3_reg;
  vlc_field_t  limit1_next;
  vlc_field_t  limit2_next;
  vlc_field_t  limit3_next;
  vlc_ctrl_t   ctrl_reg;
  vlc_ctrl_t   ctrl_next;
  logic [31:0] ctrl_word;

  logic [3:0]  impl;
  logic [3:0]  vec_use;
  logic [3:0]  fp_use;
  logic [3:0]  en_vec;
  logic [3:0]  en_fp;
  vlc_field_t  fld     [4];
  logic [1:0]  cap_from;
  vlc_chunks_t cap_chunks;
  vlc_chunks_t req_chunks;
  vlc_chunks_t rnd_chunks;
  vlc_mask_t   sup_mask;
  logic        usable_next;
  logic        preserve_next;
  logic [31:0] status_word;
  logic [31:0] caps_word;

  vlc_chunks_t eff_chunks_reg;
  vlc_field_t  eff_field_reg;
  logic        usable_reg;
  logic        preserve_reg;
  vlc_mask_t   acc_mask;
  vlc_mask_t   zero_req;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  function automatic vlc_field_t lim_write(input vlc_field_t old_v, input logic sel0, input logic [31:0] d);
    return sel0 ? d[3:0] : old_v;
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Ack one cycle after the request; writes land on the ack edge
  assign req_new = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign wr_fire = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req_new;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      dat_reg <= 32'h00000000;
    end else if (req_new) begin
      dat_reg <= WB_WE_I ? 32'h00000000 : rd_data;
    end
  end

  // ----------------------------------------
  // Limit fields
  // ----------------------------------------
  // Stored raw, never rounded, so read-back equals the write
  always_comb begin
    limit1_next = limit1_reg;
    limit2_next = limit2_reg;
    limit3_next = limit3_reg;
    if (wr_fire && hit(WB_ADR_I, `VLC_OFS_LIMIT1)) begin
      limit1_next = lim_write(limit1_reg, WB_SEL_I[0], WB_DAT_I);
    end
    if (wr_fire && HAS_LEVEL2 && hit(WB_ADR_I, `VLC_OFS_LIMIT2)) begin
      limit2_next = lim_write(limit2_reg, WB_SEL_I[0], WB_DAT_I);
    end
    if (wr_fire && HAS_LEVEL3 && hit(WB_ADR_I, `VLC_OFS_LIMIT3)) begin
      limit3_next = lim_write(limit3_reg, WB_SEL_I[0], WB_DAT_I);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      limit1_reg <= `VLC_LIMIT_RST;
    end else begin
      limit1_reg <= limit1_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      limit2_reg <= `VLC_LIMIT_RST;
    end else begin
      limit2_reg <= limit2_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      limit3_reg <= `VLC_LIMIT_RST;
    end else begin
      limit3_reg <= limit3_next;
    end
  end

  // ----------------------------------------
  // Control word
  // ----------------------------------------
  always_comb begin
    ctrl_word = 32'(ctrl_reg);
    if (wr_fire && hit(WB_ADR_I, `VLC_OFS_CTRL)) begin
      for (int b = 0; b < 4; b++) begin
        if (WB_SEL_I[b]) begin
          ctrl_word[b*8 +: 8] = WB_DAT_I[b*8 +: 8];
        end
      end
    end
    ctrl_next = vlc_ctrl_t'(ctrl_word[`VLC_CTRL_BITS-1:0] & `VLC_CTRL_BITS'(`VLC_CTRL_WMASK));
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_reg <= vlc_ctrl_t'(`VLC_CTRL_RST);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------
  // Hierarchical enables
  // ----------------------------------------
  // Computed from next values so a write is seen on its own edge
  assign impl = {HAS_LEVEL3, HAS_LEVEL2, 1'b1, 1'b0};
  assign en_vec = {ctrl_next.vec_en[2] | ~HAS_LEVEL3, ctrl_next.vec_en[1] | ~HAS_LEVEL2, ctrl_next.vec_en[0], 1'b1};
  assign en_fp  = {ctrl_next.fp_en[2] | ~HAS_LEVEL3, ctrl_next.fp_en[1] | ~HAS_LEVEL2, ctrl_next.fp_en[0], 1'b1};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_use
      // A level is usable only when it and every level above allow it
      assign vec_use[g] = &en_vec[3:g];
      assign fp_use[g]  = &en_fp[3:g];
    end
  endgenerate

  assign fld[0] = 4'h0;
  assign fld[1] = limit1_next;
  assign fld[2] = limit2_next;
  assign fld[3] = limit3_next;

  // ----------------------------------------
  // Length cap
  // ----------------------------------------
  // Level 0 obeys the level 1 limit
  assign cap_from = (ctrl_next.level == VLC_LVL0) ? 2'h1 : ctrl_next.level;

  always_comb begin
    vlc_chunks_t c;
    c = 5'h01;
    cap_chunks = MAX_CHUNKS;
    for (int k = 1; k < 4; k++) begin
      if (impl[k] && (2'(k) >= cap_from)) begin
        // Trapped or narrow level acts as field zero
        c = (vec_use[k] && !ctrl_next.narrow[k]) ? 5'({1'b0, fld[k]} + 5'h01) : 5'h01;
        if (c < cap_chunks) begin
          cap_chunks = c;
        end
      end
    end
  end

  assign usable_next = vec_use[ctrl_next.level] & ~ctrl_next.narrow[ctrl_next.level];
  assign req_chunks  = usable_next ? cap_chunks : 5'h01;

  vlc_round #(
    .MAX_CHUNKS (MAX_CHUNKS),
    .OPT_MASK   (OPT_LEN_MASK)
  ) u_round (
    .req_chunks (req_chunks),
    .out_chunks (rnd_chunks),
    .sup_mask   (sup_mask)
  );

  // ----------------------------------------
  // Preservation
  // ----------------------------------------
  always_comb begin
    preserve_next = (ctrl_next.level != VLC_LVL0);
    for (int k = 0; k < 3; k++) begin
      if ((2'(k) < ctrl_next.level) && (vec_use[k] || fp_use[k])) begin
        preserve_next = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Effective length outputs
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      eff_chunks_reg <= `VLC_CHUNKS_RST;
    end else begin
      eff_chunks_reg <= rnd_chunks;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      eff_field_reg <= `VLC_FIELD_RST;
    end else begin
      eff_field_reg <= 4'(rnd_chunks - `VLC_CHUNKS_RST);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      usable_reg <= 1'b0;
    end else begin
      usable_reg <= usable_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      preserve_reg <= 1'b0;
    end else begin
      preserve_reg <= preserve_next;
    end
  end

  vlc_access u_access (
    .clk          (CLK),
    .rst          (RST),
    .eff_chunks   (rnd_chunks),
    .zero_fill    (ctrl_next.zero_fill),
    .preserve     (preserve_next),
    .acc_mask_reg (acc_mask),
    .zero_req_reg (zero_req)
  );

  // ----------------------------------------
  // Read-only words
  // ----------------------------------------
  // Built from registered state only, so a read never sees a length mid-update
  always_comb begin
    status_word                                     = 32'h00000000;
    status_word[3:0]                                = eff_field_reg;
    status_word[`VLC_ST_CHUNKS_LSB +: 5]            = eff_chunks_reg;
    status_word[`VLC_ST_USABLE_BIT]                 = usable_reg;
    status_word[`VLC_ST_PRESERVE_BIT]               = preserve_reg;
    status_word[`VLC_ST_MASK_LSB +: `VLC_MAX_SLOTS] = acc_mask;
  end

  always_comb begin
    caps_word                                      = 32'h00000000;
    caps_word[4:0]                                 = MAX_CHUNKS;
    caps_word[`VLC_CAPS_SUP_LSB +: `VLC_MAX_SLOTS] = sup_mask;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped offsets still ack, with zero data
  always_comb begin
    rd_data = 32'h00000000;
    if (hit(WB_ADR_I, `VLC_OFS_LIMIT1)) begin
      rd_data[3:0] = limit1_reg;
    end else if (hit(WB_ADR_I, `VLC_OFS_LIMIT2)) begin
      rd_data[3:0] = HAS_LEVEL2 ? limit2_reg : 4'h0;
    end else if (hit(WB_ADR_I, `VLC_OFS_LIMIT3)) begin
      rd_data[3:0] = HAS_LEVEL3 ? limit3_reg : 4'h0;
    end else if (hit(WB_ADR_I, `VLC_OFS_CTRL)) begin
      rd_data[`VLC_CTRL_BITS-1:0] = ctrl_reg;
    end else if (hit(WB_ADR_I, `VLC_OFS_STATUS)) begin
      rd_data = status_word;
    end else if (hit(WB_ADR_I, `VLC_OFS_CAPS)) begin
      rd_data = caps_word;
    end
  end

  // ----------------------------------------
  // Ports
  // ----------------------------------------
  assign WB_ACK_O       = ack_reg;
  assign WB_DAT_O       = dat_reg;
  assign EFF_LEN_FIELD  = eff_field_reg;
  assign EFF_LEN_CHUNKS = eff_chunks_reg;
  assign VEC_USABLE     = usable_reg;
  assign STATE_PRESERVE = preserve_reg;
  assign ACC_MASK       = acc_mask;
  assign ZERO_REQ       = zero_req;

endmodule

// ==== tb/vlc_top_chk.sv ====
module vlc_top_chk #(
  parameter int unsigned MAX_LEN_BITS = 2048
) (
  input wire logic                 CLK,
  input wire logic                 RST,
  input wire logic                 WB_CYC_I,
  input wire logic                 WB_STB_I,
  input wire logic                 WB_ACK_O,
  input wire vlc_pkg::vlc_field_t  EFF_LEN_FIELD,
  input wire vlc_pkg::vlc_chunks_t EFF_LEN_CHUNKS,
  input wire logic                 VEC_USABLE,
  input wire logic                 STATE_PRESERVE,
  input wire vlc_pkg::vlc_mask_t   ACC_MASK,
  input wire vlc_pkg::vlc_mask_t   ZERO_REQ
);
  import vlc_pkg::*;
  // ----
  // Bus, length and zeroing checks
  // ----
  localparam int MAXC = MAX_LEN_BITS / 128;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_ack; WB_ACK_O ##1 !WB_ACK_O; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_len; EFF_LEN_CHUNKS == {1'b0, EFF_LEN_FIELD} + 5'h01; endproperty
  a_len: assert property (p_len) else $error("field and chunks disagree");
  property p_max; EFF_LEN_CHUNKS >= 5'h01 && int'(EFF_LEN_CHUNKS) <= MAXC; endproperty
  a_max: assert property (p_max) else $error("length out of range");
  property p_min; !VEC_USABLE |-> EFF_LEN_CHUNKS == 5'h01; endproperty
  a_min: assert property (p_min) else $error("unusable level not minimal");
  property p_mask; ACC_MASK == 16'((17'h00001 << EFF_LEN_CHUNKS) - 17'h00001); endproperty
  a_mask: assert property (p_mask) else $error("access mask wrong");
  // Zero requests only for slices that just opened, and only for one cycle
  property p_zero;
    ZERO_REQ != 16'h0000 |-> ZERO_REQ == (ACC_MASK & ~$past(ACC_MASK)) ##1 ZERO_REQ == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("zero request wrong");
  property p_keep; STATE_PRESERVE |-> ZERO_REQ == 16'h0000; endproperty
  a_keep: assert property (p_keep) else $error("zeroing while preserved");
  property p_sync; $changed(EFF_LEN_CHUNKS) |-> $past(WB_ACK_O); endproperty
  a_sync: assert property (p_sync) else $error("length moved without access");
endmodule

bind vlc_top vlc_top_chk #(.MAX_LEN_BITS(MAX_LEN_BITS)) u_chk (
  .CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .EFF_LEN_FIELD(EFF_LEN_FIELD), .EFF_LEN_CHUNKS(EFF_LEN_CHUNKS), .VEC_USABLE(VEC_USABLE),
  .STATE_PRESERVE(STATE_PRESERVE), .ACC_MASK(ACC_MASK), .ZERO_REQ(ZERO_REQ));

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vlc_pkg::*;
  // ----
  // Signals
  // ----
  logic        CLK, RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, VEC_USABLE, STATE_PRESERVE;
  logic [7:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  vlc_field_t  EFF_LEN_FIELD;
  vlc_chunks_t EFF_LEN_CHUNKS;
  vlc_mask_t   ACC_MASK, ZERO_REQ, zr;
  int          errors, n_tests;

  // No optional lengths, so rounding is visible
  vlc_top #(.OPT_LEN_MASK(16'h0000)) dut_u (
    .CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .EFF_LEN_FIELD(EFF_LEN_FIELD), .EFF_LEN_CHUNKS(EFF_LEN_CHUNKS),
    .VEC_USABLE(VEC_USABLE), .STATE_PRESERVE(STATE_PRESERVE), .ACC_MASK(ACC_MASK),
    .ZERO_REQ(ZERO_REQ));

  always #2 CLK = ~CLK;

  // ----
  // Helpers
  // ----
  task automatic give_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle; ZERO_REQ is a pulse, so it is caught just after the ack edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    @(negedge CLK);
    while (WB_ACK_O !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        give_verdict();
      end
      @(negedge CLK);
    end
    @(posedge CLK);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
    #1 zr = ZERO_REQ;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(q, e);
  endtask

  task automatic len(input logic [4:0] c);
    chk(32'(EFF_LEN_CHUNKS), 32'(c));
    chk(32'(EFF_LEN_FIELD), 32'(c - 5'h01));
    chk(32'(ACC_MASK), 32'((17'h00001 << c) - 17'h00001));
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    len(5'h01);
    chk(32'(VEC_USABLE), 32'h00000000);
    rd(8'h0C, 32'h00000000);
    rd(8'h00, 32'h00000000);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h00000000);
    rd(8'h14, 32'h808B0010);
  endtask

  task automatic t_cap();
    wr(8'h0C, 32'h00010771);
    chk(32'(VEC_USABLE), 32'h00000001);
    // Upper limits open first, else they cap level 1 at one slice
    wr(8'h04, 32'h0000000F);
    wr(8'h08, 32'h0000000F);
    wr(8'h00, 32'h00000001);
    len(5'h02);
    rd(8'h10, 32'h00030221);
  endtask

  task automatic t_round();
    logic [3:0] f[7];
    logic [4:0] e[7];
    f = '{4'h2, 4'h5, 4'h8, 4'hE, 4'hF, 4'h3, 4'h0};
    e = '{5'h02, 5'h04, 5'h08, 5'h08, 5'h10, 5'h04, 5'h01};
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, 32'(f[i]));
      len(e[i]);
      rd(8'h00, 32'(f[i]));
    end
  endtask

  task automatic t_hier();
    wr(8'h00, 32'h0000000F);
    wr(8'h04, 32'h00000003);
    len(5'h04);
    wr(8'h08, 32'h00000000);
    len(5'h01);
    wr(8'h08, 32'h0000000F);
    wr(8'h0C, 32'h00010772);
    wr(8'h00, 32'h00000000);
    len(5'h04);
    wr(8'h04, 32'h0000000F);
    wr(8'h0C, 32'h00010771);
    len(5'h01);
  endtask

  task automatic t_off();
    wr(8'h00, 32'h0000000F);
    len(5'h10);
    wr(8'h0C, 32'h00010751);
    len(5'h01);
    chk(32'(VEC_USABLE), 32'h00000000);
    rd(8'h00, 32'h0000000F);
    wr(8'h0C, 32'h00012771);
    len(5'h01);
  endtask

  task automatic t_zero();
    wr(8'h0C, 32'h00010771);
    chk(32'(zr), 32'h0000FFFE);
    wr(8'h00, 32'h00000000);
    wr(8'h0C, 32'h00000771);
    wr(8'h00, 32'h0000000F);
    len(5'h10);
    chk(32'(zr), 32'h00000000);
  endtask

  task automatic t_keep();
    wr(8'h0C, 32'h00010662);
    chk(32'(STATE_PRESERVE), 32'h00000001);
    wr(8'h04, 32'h00000000);
    len(5'h01);
    wr(8'h04, 32'h0000000F);
    len(5'h10);
    chk(32'(zr), 32'h00000000);
  endtask

  initial begin
    CLK = 1'b0;
    RST = 1'b1;
    WB_CYC_I = 1'b0;
    WB_STB_I = 1'b0;
    WB_WE_I = 1'b0;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'hF;
    WB_DAT_I = 32'h00000000;
    errors = 0;
    n_tests = 0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_cap();
    t_round();
    t_hier();
    t_off();
    t_zero();
    t_keep();
    give_verdict();
  end
endmodule
